// [common/afp_pkg.sv]
// Package: constants and types for the amplifier fault protection controller
package afp_pkg;
    // Clock rate
    localparam int unsigned CLK_HZ = 100_000_000;
    // Start-up interval after shutdown release, in microseconds
    localparam int unsigned STARTUP_US = 10_000;
    localparam int unsigned STARTUP_CYC = STARTUP_US * (CLK_HZ / 1_000_000);
    // DC-detect persistence, in milliseconds (event needs more than this)
    localparam int unsigned DC_DET_MS = 625;
    localparam longint unsigned DC_DET_CYC = 64'(DC_DET_MS) * 64'(CLK_HZ / 1000);
    // Counter width for the long timers
    localparam int unsigned TMR_W = 27;
    // Reset values
    localparam logic RST_LATCH = 1'b0;

    // Latched fault set
    typedef struct packed {
        logic over_current;
        logic over_temp;
        logic dc_detect;
    } afp_latch_s;

    // Sense inputs from the analog monitors
    typedef struct packed {
        logic supply_under;
        logic supply_over;
        logic over_current;
        logic over_temp;
        logic [1:0] duty_hi_pos;
        logic [1:0] duty_hi_neg;
    } afp_sense_s;

    // Control sequencer states
    typedef enum logic [1:0] {
        ST_SHUTDOWN = 2'b00,
        ST_STARTUP = 2'b01,
        ST_RUN = 2'b10
    } afp_state_e;
endpackage

// [rtl/afp_dc_timer.sv]
// DC-detect persistence timer for one channel polarity
`timescale 1ns/1ps
module afp_dc_timer #(
    parameter logic [26:0] LIMIT = 27'(afp_pkg::DC_DET_CYC)
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic level_i,
    output logic trip_o
);
    logic [26:0] cnt_q;
    logic [26:0] cnt_d;
    logic trip_q;
    logic trip_d;

    // Count continuous high time; any drop restarts the count
    always_comb begin
        cnt_d = cnt_q;
        trip_d = 1'b0;
        if (clear_i || !level_i) begin
            cnt_d = '0;
        end else if (cnt_q < LIMIT) begin
            cnt_d = cnt_q + 27'd1;
        end else begin
            trip_d = 1'b1;
        end
    end

    // Register counter and trip flag, held while the level stays high past the limit
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            trip_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            trip_q <= trip_d;
        end
    end

    assign trip_o = trip_q;
endmodule

// [rtl/afp_ctrl.sv]
// Fault supervision and output-stage shutdown control
// Function
// - Supply out of range: Hi-Z, no fault
// - Over-current latches fault, fault line low
// - Over-current latch forces outputs Hi-Z
// - Latches clear only by shutdown low pulse
// - Over-temperature latches, outputs disabled
// - Over-temperature latch drives fault line low
// - Duty above 63% over 625 ms trips
// - DC-detect latches, fault low, outputs Hi-Z
// - 10 ms start-up before amplification
// - Shutdown low mutes, enters low current
`timescale 1ns/1ps
module afp_ctrl #(
    // Cycle counts; a bench may shrink them to keep runs short
    parameter int unsigned STARTUP_CYC = afp_pkg::STARTUP_CYC,
    parameter int unsigned DC_DET_CYC = 32'(afp_pkg::DC_DET_CYC)
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic shutdown_n_input_i,
    input wire afp_pkg::afp_sense_s sense_i,
    output logic out_enable_o,
    output logic low_power_o,
    output logic fault_n_output_o,
    output logic fault_n_output_oe_o,
    output afp_pkg::afp_latch_s latch_o
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int unsigned SW = $bits(afp_pkg::afp_sense_s) + 1;
    logic [SW-1:0] sync1_q;
    logic [SW-1:0] sync2_q;
    logic [SW-1:0] sync1_d;
    logic [SW-1:0] sync2_d;
    afp_pkg::afp_sense_s sense;
    logic sd_n;
    logic sd_n_prev_q;
    logic sd_n_prev_d;

    // Two flops on every asynchronous input
    always_comb begin
        sync1_d = {shutdown_n_input_i, sense_i};
        sync2_d = sync1_q;
        sd_n_prev_d = sd_n;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sd_n_prev_q <= 1'b0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sd_n_prev_q <= sd_n_prev_d;
        end
    end

    assign sd_n = sync2_q[SW-1];
    assign sense = afp_pkg::afp_sense_s'(sync2_q[SW-2:0]);

    // ------------------------------------------------------------
    // DC-detect timers
    // ------------------------------------------------------------
    localparam logic [26:0] DC_LIMIT = 27'(DC_DET_CYC);
    logic [3:0] dc_level;
    logic [3:0] dc_trip;
    logic dc_any;

    assign dc_level = {sense.duty_hi_neg, sense.duty_hi_pos};

    // One timer per channel and polarity
    for (genvar g = 0; g < 4; g++) begin : g_dc
        afp_dc_timer #(
            .LIMIT(DC_LIMIT)
        ) u_dc (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .clear_i(!sd_n),
            .level_i(dc_level[g]),
            .trip_o(dc_trip[g])
        );
    end
    assign dc_any = |dc_trip;

    // ------------------------------------------------------------
    // Fault latches
    // ------------------------------------------------------------
    afp_pkg::afp_latch_s latch_q;
    afp_pkg::afp_latch_s latch_d;
    logic sd_rise;
    logic any_latch;

    // Clear on return high after low; set beats clear
    assign sd_rise = sd_n && !sd_n_prev_q;
    always_comb begin
        latch_d = latch_q;
        if (sd_rise) begin
            latch_d = '0;
        end
        if (sense.over_current) begin
            latch_d.over_current = 1'b1;
        end
        if (sense.over_temp) begin
            latch_d.over_temp = 1'b1;
        end
        if (dc_any) begin
            latch_d.dc_detect = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            latch_q <= '{default: afp_pkg::RST_LATCH};
        end else begin
            latch_q <= latch_d;
        end
    end
    assign any_latch = |latch_q;

    // ------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------
    localparam logic [26:0] SU_LAST = 27'(STARTUP_CYC - 1);
    afp_pkg::afp_state_e state_q;
    afp_pkg::afp_state_e state_d;
    logic [26:0] su_cnt_q;
    logic [26:0] su_cnt_d;
    logic supply_bad;
    logic en_q;
    logic en_d;

    assign supply_bad = sense.supply_under || sense.supply_over;

    // Shutdown, start-up wait, run
    always_comb begin
        state_d = state_q;
        su_cnt_d = su_cnt_q;
        unique case (state_q)
            afp_pkg::ST_SHUTDOWN: begin
                su_cnt_d = '0;
                if (sd_n) begin
                    state_d = afp_pkg::ST_STARTUP;
                end
            end
            afp_pkg::ST_STARTUP: begin
                if (!sd_n) begin
                    state_d = afp_pkg::ST_SHUTDOWN;
                end else if (su_cnt_q == SU_LAST) begin
                    state_d = afp_pkg::ST_RUN;
                end else begin
                    su_cnt_d = su_cnt_q + 27'd1;
                end
            end
            afp_pkg::ST_RUN: begin
                if (!sd_n) begin
                    state_d = afp_pkg::ST_SHUTDOWN;
                end
            end
            default: begin
                state_d = afp_pkg::ST_SHUTDOWN;
            end
        endcase
        // Output gate
        en_d = (state_d == afp_pkg::ST_RUN) && sd_n && !(|latch_d) && !supply_bad;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= afp_pkg::ST_SHUTDOWN;
            su_cnt_q <= '0;
            en_q <= 1'b0;
        end else begin
            state_q <= state_d;
            su_cnt_q <= su_cnt_d;
            en_q <= en_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open-drain fault line: drive low while any latch is set
    assign out_enable_o = en_q;
    assign low_power_o = (state_q == afp_pkg::ST_SHUTDOWN);
    assign fault_n_output_o = 1'b0;
    assign fault_n_output_oe_o = any_latch;
    assign latch_o = latch_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_supply_no_fault;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        supply_bad && !any_latch |=> !out_enable_o;
    endproperty
    a_supply_no_fault: assert property (p_supply_no_fault)
        else $error("Outputs enabled with supply out of range");

    property p_oc_latch;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        sense.over_current |=> latch_q.over_current && fault_n_output_oe_o;
    endproperty
    a_oc_latch: assert property (p_oc_latch)
        else $error("Over-current did not latch fault");

    property p_oc_hiz;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        latch_q.over_current |-> !out_enable_o;
    endproperty
    a_oc_hiz: assert property (p_oc_hiz)
        else $error("Outputs on while over-current latched");

    property p_latch_hold;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        any_latch && !sd_rise |=> any_latch;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("Latch cleared without shutdown cycle");

    property p_ot_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        sense.over_temp |=> !out_enable_o && latch_q.over_temp;
    endproperty
    a_ot_off: assert property (p_ot_off)
        else $error("Over-temperature did not disable outputs");

    property p_fault_line;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        fault_n_output_oe_o == (latch_q != '0);
    endproperty
    a_fault_line: assert property (p_fault_line)
        else $error("Fault line does not follow latches");

    property p_dc_trip;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        dc_any |=> latch_q.dc_detect ##0 !out_enable_o;
    endproperty
    a_dc_trip: assert property (p_dc_trip)
        else $error("DC-detect did not latch and disable");

    property p_dc_short;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(dc_level[0]) ##1 !dc_level[0] |-> ##[1:3] !dc_trip[0];
    endproperty
    a_dc_short: assert property (p_dc_short)
        else $error("Short excursion tripped DC-detect");

    property p_startup;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        state_q == afp_pkg::ST_STARTUP |-> !out_enable_o;
    endproperty
    a_startup: assert property (p_startup)
        else $error("Outputs enabled during start-up");

    property p_sd_low;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !sd_n |=> !out_enable_o ##0 low_power_o;
    endproperty
    a_sd_low: assert property (p_sd_low)
        else $error("Shutdown low did not mute");

    property p_enable_cause;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        out_enable_o |-> sd_n_prev_q && state_q == afp_pkg::ST_RUN && !any_latch;
    endproperty
    a_enable_cause: assert property (p_enable_cause)
        else $error("Outputs enabled without all conditions");

    c_oc: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $rose(latch_q.over_current));
    c_clear: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) any_latch && sd_rise);
    c_run: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $rose(out_enable_o));
    c_dc: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) dc_any);
endmodule

// [tb/afp_host_model.sv]
// Host-side model that drives the shutdown pin and watches the fault line
`timescale 1ns/1ps
module afp_host_model (
    input wire logic clk_sys_i,
    input wire logic fault_line_i,
    output logic shutdown_n_o,
    output logic mute_n_o
);
    // Pin held low from power-up until inputs have settled
    initial begin
        shutdown_n_o = 1'b0;
    end

    // Mute follows the fault line directly, low while a fault is reported
    assign mute_n_o = fault_line_i;

    // Change the pin level just after a clock edge
    task automatic set_pin(input logic level);
        @(posedge clk_sys_i);
        #1;
        shutdown_n_o = level;
    endtask

    // Clear latched faults with a low pulse of the given length
    task automatic clear_pulse(input int cycles);
        set_pin(1'b0);
        repeat (cycles) @(posedge clk_sys_i);
        #1;
        shutdown_n_o = 1'b1;
    endtask

    // Fault line tied back to the pin: a report pulls it low, then releases
    task automatic recover(input int limit);
        int n;
        n = 0;
        while (fault_line_i !== 1'b0 && n < limit) begin
            @(posedge clk_sys_i);
            n++;
        end
        clear_pulse(2);
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking testbench for the fault protection controller
`timescale 1ns/1ps
module testbench;
    // Shortened counts so every phase fits in the run
    localparam int unsigned SU_CYC = 200;
    localparam int unsigned DC_CYC = 300;
    logic clk_sys_i;
    logic mute_n;
    logic rst_n_i;
    logic shutdown_n;
    afp_pkg::afp_sense_s sense;
    logic out_enable;
    logic low_power;
    logic fault_n;
    logic fault_oe;
    afp_pkg::afp_latch_s latch;
    logic fault_line;
    logic [31:0] rnd;
    int fails;
    int compares;
    int seed;
    string name_q[$];
    logic [6:0] exp_q[$];
    event sample_ev;

    // --------------------------------
    // Clock, open-drain line, design
    // --------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // Pull-up unless the design pulls the line low
    assign fault_line = (fault_oe === 1'b1) ? fault_n : 1'b1;

    afp_host_model host (
        .clk_sys_i(clk_sys_i),
        .fault_line_i(fault_line),
        .shutdown_n_o(shutdown_n),
        .mute_n_o(mute_n)
    );

    afp_ctrl #(
        .STARTUP_CYC(SU_CYC),
        .DC_DET_CYC(DC_CYC)
    ) dut (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .shutdown_n_input_i(shutdown_n),
        .sense_i(sense),
        .out_enable_o(out_enable),
        .low_power_o(low_power),
        .fault_n_output_o(fault_n),
        .fault_n_output_oe_o(fault_oe),
        .latch_o(latch)
    );

    // --------------------------------
    // Helpers
    // --------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    // Note an expectation and wake the monitor
    task automatic expect_now(input string name, input logic [6:0] exp);
        name_q.push_back(name);
        exp_q.push_back(exp);
        -> sample_ev;
    endtask

    // Monitor: oldest note against {data, enable, low power, oe, latches}
    always @(sample_ev) begin
        string nm;
        logic [6:0] ex;
        logic [6:0] seen;
        while (exp_q.size() > 0) begin
            nm = name_q.pop_front();
            ex = exp_q.pop_front();
            seen = {fault_n, out_enable, low_power, fault_oe, latch};
            compares++;
            if (seen !== ex) begin
                fails++;
                $display("Error %s expected %b seen %b", nm, ex, seen);
            end
            compares++;
            if (mute_n !== !ex[3]) begin
                fails++;
                $display("Error %s mute expected %b seen %b", nm, !ex[3], mute_n);
            end
        end
    end

    task automatic report_and_stop;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #200_000;
        fails++;
        report_and_stop();
    end

    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        fails = 0;
        compares = 0;
        seed = 62134;
        rst_n_i = 1'b0;
        sense = '0;
        repeat (5) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        tick(3);
        expect_now("idle_shutdown", 7'b0010000);
        // Over-current while the pin is low is kept
        sense.over_current = 1'b1;
        tick(2);
        sense.over_current = 1'b0;
        tick(5);
        expect_now("oc_while_low", 7'b0011100);
        // Rising pin clears the latch and starts up
        host.set_pin(1'b1);
        tick(5);
        expect_now("release_clears", 7'b0000000);
        // Over-temperature latches and reports
        sense.over_temp = 1'b1;
        tick(2);
        sense.over_temp = 1'b0;
        tick(5);
        expect_now("over_temp", 7'b0001010);
        sense.over_current = 1'b1;
        tick(2);
        sense.over_current = 1'b0;
        tick(5);
        expect_now("oc_and_ot", 7'b0001110);
        // Random supply faults and short duty excursions
        for (int i = 0; i < 200; i++) begin
            rnd = $random(seed);
            sense.supply_under = rnd[0];
            sense.supply_over = rnd[1];
            sense.duty_hi_pos = rnd[3:2];
            sense.duty_hi_neg = rnd[5:4];
            tick(1);
        end
        sense = '0;
        tick(5);
        expect_now("supply_no_fault", 7'b0001110);
        // Low pulse clears everything
        host.clear_pulse(3);
        tick(5);
        expect_now("pulse_clears", 7'b0000000);
        // Supply fault during start-up gives no fault report
        sense.supply_over = 1'b1;
        tick(5);
        expect_now("supply_in_startup", 7'b0000000);
        sense.supply_over = 1'b0;
        // Outputs stay off through the start-up interval
        for (int i = 0; i < 37; i++) begin
            tick(5);
            expect_now("startup_hold", 7'b0000000);
        end
        // Start-up done: outputs enabled
        tick(10);
        expect_now("run_enabled", 7'b0100000);
        // Supply fault in run: Hi-Z, no report, then resume
        sense.supply_under = 1'b1;
        tick(5);
        expect_now("supply_in_run", 7'b0000000);
        sense.supply_under = 1'b0;
        tick(5);
        expect_now("supply_resume", 7'b0100000);
        // Excursion of exactly the limit does not trip
        sense.duty_hi_pos[1] = 1'b1;
        tick(DC_CYC);
        sense.duty_hi_pos[1] = 1'b0;
        tick(5);
        expect_now("dc_short", 7'b0100000);
        // Longer than the limit trips, latches and reports
        sense.duty_hi_neg[0] = 1'b1;
        tick(DC_CYC + 8);
        expect_now("dc_trip", 7'b0001001);
        sense.duty_hi_neg[0] = 1'b0;
        // Fault line tied back to the pin clears the latch
        host.recover(20);
        tick(5);
        expect_now("auto_recover", 7'b0000000);
        // Pin low again enters low-current state
        host.set_pin(1'b0);
        tick(5);
        expect_now("shutdown_again", 7'b0010000);
        tick(2);
        report_and_stop();
    end
endmodule
